// ---- dol_ctrl.sv ----
// Output-state, lock status, equalizer and self-test control of the link receiver
//
// Behaviour
// R1: Powerdown-bar high starts clock-data recovery acquiring lock on the serial stream.
// R2: Lock sequence complete drives lock high; recovered data and clock are valid.
// R3: Powerdown-bar low tri-states all; output enable low drives low or tri-states. The monitor pair and irq are driven low instead.
// R4: Enabled, static link: lock/data low; select 0 clock low or oscillator; 1 flag high.
// R5: Enabled, active link: lock high; select 0 holds low, select 1 passes live.
// R6: Equalizer adapts on its own; a register can force a manual level.
// R7: Equalized serial signal is shown on a differential monitor pair.
// R8: Parallel outputs switch in random slots spread over a fixed window.
// R9: Powerdown-bar low returns every control register to its default.
// R10: In self-test the result flag pulses low once for each errored frame.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dol_consts.svh"
module dol_ctrl
  import dol_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Control pins
  input  wire logic        powerdown_bar,
  input  wire logic        output_drive_enable,
  input  wire logic        idle_output_state_select,
  input  wire logic        self_test_enable,
  // Serial link after the front end
  input  wire logic        link_clk,
  input  wire logic        link_data,
  // Parallel outputs with enables, then the monitor pair and interrupt without enables
  output logic             lock_o,
  output logic             lock_oe,
  output logic             pass_o,
  output logic             pass_oe,
  output logic [7:0]       audio_data,
  output logic             audio_data_oe,
  output logic             sys_clk_out,
  output logic             sys_clk_out_oe,
  output logic             equalizer_monitor_p,
  output logic             equalizer_monitor_n,
  output logic             irq,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ==========================================================
  // Pin synchronisers
  logic [5:0]      sync_m_r;
  logic [5:0]      sync_s_r;
  logic            clk_q_r;
  logic            pdb_q_r;
  logic            bist_q_r;
  logic            pdb_s;
  logic            oen_s;
  logic            oss_s;
  logic            bist_s;
  logic            clk_s;
  logic            data_s;
  logic            link_edge;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_m_r <= 6'h00;
      sync_s_r <= 6'h00;
    end else begin
      sync_m_r <= {powerdown_bar, output_drive_enable, idle_output_state_select,
                   self_test_enable, link_clk, link_data};
      sync_s_r <= sync_m_r;
    end
  end

  assign {pdb_s, oen_s, oss_s, bist_s, clk_s, data_s} = sync_s_r;
  assign link_edge = clk_s & ~clk_q_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_q_r  <= 1'b0;
      pdb_q_r  <= 1'b0;
      bist_q_r <= 1'b0;
    end else begin
      clk_q_r  <= clk_s;
      pdb_q_r  <= pdb_s;
      bist_q_r <= bist_s;
    end
  end

  // ==========================================================
  // Link activity and lock sequence
  dol_lock_state_t state_r;
  logic [7:0]      idle_cnt_r;
  logic [7:0]      edge_cnt_r;
  logic            active;
  logic            locked;

  assign active = (idle_cnt_r < 8'(`DOL_ACT_TO_CYC));
  assign locked = (state_r == ST_LOCK);

  // An edge gap longer than the timeout marks the link static
  always_ff @(posedge clk_sys) begin
    if (reset || link_edge) begin
      idle_cnt_r <= 8'h00;
    end else if (active) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !pdb_s) begin
      state_r    <= ST_DOWN;
      edge_cnt_r <= 8'h00;
    end else begin
      unique case (state_r)
        ST_DOWN: begin
          state_r    <= ST_ACQ;                         // [R1]
          edge_cnt_r <= 8'h00;
        end
        ST_ACQ: begin
          // An edge counts even when it ends an idle gap
          if (link_edge) begin
            if (edge_cnt_r == 8'(`DOL_LOCK_EDGES - 1)) begin
              state_r <= ST_LOCK;                       // [R2]
            end
            edge_cnt_r <= edge_cnt_r + 8'h01;
          end else if (!active) begin
            edge_cnt_r <= 8'h00;
          end
        end
        ST_LOCK: begin
          if (!active) begin
            state_r    <= ST_ACQ;
            edge_cnt_r <= 8'h00;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Frame capture and self-test check (even parity over nine bits)
  logic [8:0]      shift_r;
  logic [3:0]      bit_cnt_r;
  logic            frame_done_r;
  logic            frame_err_r;
  logic [2:0]      pass_low_r;
  logic [7:0]      err_cnt_r;
  dol_stg_if       stg_if ();

  always_ff @(posedge clk_sys) begin
    if (reset || !locked) begin
      shift_r      <= 9'h000;
      bit_cnt_r    <= 4'h0;
      frame_done_r <= 1'b0;
      frame_err_r  <= 1'b0;
    end else begin
      frame_done_r <= 1'b0;
      frame_err_r  <= 1'b0;
      if (link_edge) begin
        shift_r <= {shift_r[7:0], data_s};
        if (bit_cnt_r == 4'(`DOL_FRAME_BITS - 1)) begin
          bit_cnt_r    <= 4'h0;
          frame_done_r <= 1'b1;
          frame_err_r  <= ^{shift_r[7:0], data_s};
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end
    end
  end

  // One low pulse per errored frame so the frames can be counted
  always_ff @(posedge clk_sys) begin
    if (reset || !bist_s) begin
      pass_low_r <= 3'h0;
    end else if (frame_err_r) begin
      pass_low_r <= 3'(`DOL_PASS_LOW_CYC);              // [R10]
    end else if (pass_low_r != 3'h0) begin
      pass_low_r <= pass_low_r - 3'h1;
    end
  end

  // Count survives the end of a session; a new session restarts it
  always_ff @(posedge clk_sys) begin
    if (reset || (bist_s && !bist_q_r)) begin
      err_cnt_r <= 8'h00;
    end else if (bist_s && frame_err_r && err_cnt_r != 8'hff) begin
      err_cnt_r <= err_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stg_if.load    <= 1'b0;
      stg_if.word_in <= 8'h00;
    end else begin
      stg_if.load    <= frame_done_r;
      stg_if.word_in <= shift_r[8:1];
    end
  end

  dol_stagger u_stagger (
    .clk_sys (clk_sys),
    .reset   (reset),
    .stg     (stg_if.stg)
  );

  // ==========================================================
  // AXI4-Lite slave
  logic [7:0]      ctrl_r;
  logic [4:0]      eq_r;
  logic [2:0]      irq_st_r;
  logic [2:0]      irq_en_r;
  logic [7:0]      awaddr_q_r;
  logic [31:0]     wdata_q_r;
  logic            wstrb0_q_r;
  logic            do_wr;
  logic [3:0]      wr_idx;
  logic [3:0]      rd_idx;
  logic [3:0]      eq_level_r;

  // Word index of an address, or 4'hf when nothing lives there
  function automatic logic [3:0] dol_dec(input logic [7:0] a);
    logic [3:0] idx;
    idx = a[5:2];
    if (a[1:0] != 2'h0 || a[7:6] != 2'h0) begin
      dol_dec = 4'hf;
    end else if (idx >= 4'(`DOL_IDX_CTRL) && idx <= 4'(`DOL_IDX_ERRCNT)) begin
      dol_dec = idx;
    end else begin
      dol_dec = 4'hf;
    end
  endfunction : dol_dec

  assign do_wr  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = dol_dec(awaddr_q_r);
  assign rd_idx = dol_dec(s_axi_araddr);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      awaddr_q_r    <= 8'h00;
      wdata_q_r     <= 32'h00000000;
      wstrb0_q_r    <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q_r    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q_r    <= s_axi_wdata;
        wstrb0_q_r   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx == 4'hf) ? 2'h2 : 2'h0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= (rd_idx == 4'hf) ? 2'h2 : 2'h0;
      unique case (rd_idx)
        4'(`DOL_IDX_CTRL):   s_axi_rdata <= {24'h000000, ctrl_r};
        4'(`DOL_IDX_EQ):     s_axi_rdata <= {27'h0000000, eq_r};
        4'(`DOL_IDX_STAT):   s_axi_rdata <= {24'h000000, eq_level_r, 1'b0,
                                             bist_s, active, locked};
        4'(`DOL_IDX_IRQ_ST): s_axi_rdata <= {29'h00000000, irq_st_r};
        4'(`DOL_IDX_IRQ_EN): s_axi_rdata <= {29'h00000000, irq_en_r};
        4'(`DOL_IDX_ERRCNT): s_axi_rdata <= {24'h000000, err_cnt_r};
        default:             s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Configuration drops to defaults whenever the part is powered down
  always_ff @(posedge clk_sys) begin
    if (reset || !pdb_s) begin
      ctrl_r   <= `DOL_CTRL_RST;                        // [R9]
      eq_r     <= `DOL_EQ_RST;
      irq_en_r <= `DOL_IRQ_EN_RST;
    end else if (do_wr && wstrb0_q_r) begin
      if (wr_idx == 4'(`DOL_IDX_CTRL)) begin
        ctrl_r <= wdata_q_r[7:0];
      end
      if (wr_idx == 4'(`DOL_IDX_EQ)) begin
        eq_r <= wdata_q_r[4:0];
      end
      if (wr_idx == 4'(`DOL_IDX_IRQ_EN)) begin
        irq_en_r <= wdata_q_r[2:0];
      end
    end
  end

  // ==========================================================
  // Interrupts: a new event wins over a clear in the same cycle
  logic [2:0]      irq_ev;
  logic [2:0]      irq_clr;
  logic            locked_q_r;

  assign irq_ev  = {frame_err_r & bist_s, locked_q_r & ~locked, locked & ~locked_q_r};
  assign irq_clr = (do_wr && wstrb0_q_r && wr_idx == 4'(`DOL_IDX_IRQ_CLR)) ?
                   wdata_q_r[2:0] : 3'h0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      locked_q_r <= 1'b0;
      irq_st_r   <= 3'h0;
      irq        <= 1'b0;
    end else begin
      locked_q_r <= locked;
      irq_st_r   <= (irq_st_r & ~irq_clr) | irq_ev;
      irq        <= |(irq_st_r & irq_en_r);
    end
  end

  // ==========================================================
  // Adaptive equalizer with manual override
  logic [7:0]      adapt_cnt_r;
  logic [3:0]      adapt_lvl_r;
  logic            eq_man;

  assign eq_man = eq_r[`DOL_EQ_MAN_BIT];

  // Steps the gain every DOL_ADAPT_CYC cycles spent acquiring, holds it once locked
  always_ff @(posedge clk_sys) begin
    if (reset || !pdb_s) begin
      adapt_cnt_r <= 8'h00;
      adapt_lvl_r <= 4'h0;
    end else if (state_r == ST_ACQ) begin
      if (adapt_cnt_r == 8'(`DOL_ADAPT_CYC - 1)) begin
        adapt_cnt_r <= 8'h00;
        adapt_lvl_r <= adapt_lvl_r + 4'h1;             // [R6]
      end else begin
        adapt_cnt_r <= adapt_cnt_r + 8'h01;
      end
    end else begin
      adapt_cnt_r <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      eq_level_r <= 4'h0;
    end else begin
      eq_level_r <= eq_man ? eq_r[`DOL_EQ_VAL_LSB +: 4] : adapt_lvl_r; // [R6]
    end
  end

  // Monitor pair shows the received level; quiet while powered down
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      equalizer_monitor_p <= 1'b0;
      equalizer_monitor_n <= 1'b0;
    end else begin
      equalizer_monitor_p <= pdb_s & data_s;            // [R7]
      equalizer_monitor_n <= pdb_s & ~data_s;           // [R7]
    end
  end

  // ==========================================================
  // Internal oscillator for the idle system clock
  logic [2:0]      osc_cnt_r;
  logic            osc_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      osc_cnt_r <= 3'h0;
      osc_r     <= 1'b0;
    end else if (osc_cnt_r == 3'(`DOL_OSC_HALF_CYC - 1)) begin
      osc_cnt_r <= 3'h0;
      osc_r     <= ~osc_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 3'h1;
    end
  end

  // ==========================================================
  // Output states
  logic            live;
  logic            idle_osc;

  assign live     = oen_s && locked && oss_s;
  assign idle_osc = oen_s && !locked && !oss_s && ctrl_r[`DOL_CTRL_OSC_BIT];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lock_o         <= 1'b0;
      lock_oe        <= 1'b0;
      pass_o         <= 1'b0;
      pass_oe        <= 1'b0;
      audio_data     <= 8'h00;
      audio_data_oe  <= 1'b0;
      sys_clk_out    <= 1'b0;
      sys_clk_out_oe <= 1'b0;
    end else begin
      lock_oe        <= pdb_s;                          // [R3]
      lock_o         <= pdb_s && locked;                // [R2]
      pass_oe        <= pdb_s && (oen_s || !oss_s);     // [R3]
      audio_data_oe  <= pdb_s && (oen_s || !oss_s);
      sys_clk_out_oe <= pdb_s && (oen_s || !oss_s);
      audio_data     <= live ? stg_if.word_out : 8'h00; // [R4] [R5]
      if (!oen_s) begin
        pass_o <= 1'b0;
      end else if (!locked) begin
        pass_o <= oss_s;                                // [R4]
      end else begin
        pass_o <= oss_s && (pass_low_r == 3'h0);        // [R5] [R10]
      end
      sys_clk_out <= live ? clk_s : (idle_osc ? osc_r : 1'b0); // [R4] [R5]
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_acq_start: assert property (pdb_s && !pdb_q_r |=> state_r == ST_ACQ) // [R1]
    else $error("lock acquisition did not start at power-up");

  a_lock_edges: assert property ($rose(locked) |-> $past(edge_cnt_r) == 8'h0f) // [R2]
    else $error("lock reached with wrong edge count");

  a_lock_pin: assert property (pdb_s && locked |=> lock_o && lock_oe) // [R2]
    else $error("lock pin not high while locked");

  a_pdb_tristate: assert property (!pdb_s |=> !lock_oe && !pass_oe // [R3]
    && !audio_data_oe && !sys_clk_out_oe)
    else $error("outputs driven while powered down");

  a_oen_low_z: assert property (pdb_s && !oen_s && oss_s |=> !pass_oe && !audio_data_oe) // [R3]
    else $error("disabled outputs not tri-stated for select 1");

  a_static_low: assert property (pdb_s && oen_s && !locked |=> audio_data == 8'h00 // [R4]
    && pass_o == $past(oss_s))
    else $error("static link outputs wrong");

  a_idle_hold: assert property (oen_s && locked && !oss_s |=> audio_data == 8'h00 // [R5]
    && !pass_o && !sys_clk_out)
    else $error("active link with select 0 not held low");

  a_eq_manual: assert property (eq_man ##1 eq_man |-> eq_level_r == $past(eq_r[4:1])) // [R6]
    else $error("manual equalizer level not applied");

  a_mon_follow: assert property (pdb_s |=> equalizer_monitor_p == $past(data_s) // [R7]
    && equalizer_monitor_n == !$past(data_s))
    else $error("monitor pair does not follow input");

  a_cfg_default: assert property (!pdb_s |=> ctrl_r == 8'h00 && eq_r == 5'h00) // [R9]
    else $error("configuration not returned to default");

  a_pass_pulse: assert property (bist_s && frame_err_r ##1 bist_s // [R10]
    |-> pass_low_r == 3'h4)
    else $error("errored frame did not start a low pulse");
endmodule : dol_ctrl

// ---- dol_consts.svh ----
// Constants of the output-state and lock control: offsets, fields, resets, timing
`ifndef DOL_CONSTS_SVH
`define DOL_CONSTS_SVH
// ==========================================================
// Register word indexes (byte address is four times the index)
`define DOL_IDX_CTRL     2
`define DOL_IDX_EQ       3
`define DOL_IDX_STAT     4
`define DOL_IDX_IRQ_ST   5
`define DOL_IDX_IRQ_CLR  6
`define DOL_IDX_IRQ_EN   7
`define DOL_IDX_ERRCNT   8
// ==========================================================
// Field positions
`define DOL_CTRL_OSC_BIT 5
`define DOL_EQ_MAN_BIT   0
`define DOL_EQ_VAL_LSB   1
`define DOL_IRQ_LOCK_UP  0
`define DOL_IRQ_LOCK_DN  1
`define DOL_IRQ_FRM_ERR  2
// ==========================================================
// Reset values
`define DOL_CTRL_RST     8'h00
`define DOL_EQ_RST       5'h00
`define DOL_IRQ_EN_RST   3'h0
// ==========================================================
// Timing
`define DOL_CLK_MHZ      40
`define DOL_ACT_TO_NS    1000
`define DOL_ACT_TO_CYC   ((`DOL_ACT_TO_NS * `DOL_CLK_MHZ) / 1000)
`define DOL_PASS_LOW_NS  100
`define DOL_PASS_LOW_CYC ((`DOL_PASS_LOW_NS * `DOL_CLK_MHZ + 999) / 1000)
`define DOL_ADAPT_NS     2000
`define DOL_ADAPT_CYC    ((`DOL_ADAPT_NS * `DOL_CLK_MHZ) / 1000)
`define DOL_OSC_HALF_NS  100
`define DOL_OSC_HALF_CYC ((`DOL_OSC_HALF_NS * `DOL_CLK_MHZ + 999) / 1000)
`define DOL_LOCK_EDGES   16
`define DOL_FRAME_BITS   9
`define DOL_STG_SLOTS    8
`endif

// ---- dol_pkg.sv ----
// Types shared by the output-state and lock control
package dol_pkg;
  typedef enum logic [1:0] {ST_DOWN, ST_ACQ, ST_LOCK} dol_lock_state_t;
  typedef logic [7:0] dol_word_t;
endpackage : dol_pkg

// ---- dol_stg_if.sv ----
// Carrier between the control and the output stagger
`timescale 1ns/1ps
interface dol_stg_if;
  logic       load;
  logic [7:0] word_in;
  logic [7:0] word_out;
  modport ctrl (output load, output word_in, input word_out);
  modport stg  (input load, input word_in, output word_out);
endinterface : dol_stg_if

// ---- dol_stagger.sv ----
// Staggered update of the parallel data word in pseudo-random slots
`timescale 1ns/1ps
`include "dol_consts.svh"
module dol_stagger
  import dol_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Word to stagger
  dol_stg_if.stg   stg
);
  logic [23:0] lfsr_r;
  logic [23:0] slot_r;
  logic [2:0]  cnt_r;
  logic        busy_r;
  dol_word_t   hold_r;

  // Taps 24,23,22,17 give a maximal sequence; never all-zero after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lfsr_r <= 24'h000001;
    end else begin
      lfsr_r <= {lfsr_r[22:0], lfsr_r[23] ^ lfsr_r[22] ^ lfsr_r[21] ^ lfsr_r[16]};
    end
  end

  // Each bit moves in its own random slot inside an eight-cycle window
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slot_r       <= 24'h000000;
      cnt_r        <= 3'h0;
      busy_r       <= 1'b0;
      hold_r       <= 8'h00;
      stg.word_out <= 8'h00;
    end else if (stg.load) begin
      hold_r <= stg.word_in;
      slot_r <= lfsr_r;
      cnt_r  <= 3'h0;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      for (int i = 0; i < 8; i++) begin
        if (slot_r[i*3 +: 3] == cnt_r) begin
          stg.word_out[i] <= hold_r[i];                 // [R8]
        end
      end
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'(`DOL_STG_SLOTS - 1)) begin
        busy_r <= 1'b0;
      end
    end
  end

  a_stagger_done: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
    busy_r && cnt_r == 3'h7 && !stg.load |=> stg.word_out == $past(hold_r))
    else $error("staggered word not complete at end of window");
endmodule : dol_stagger

// ---- dol_ser_model.sv ----
// Behavioural serializer that drives the serial link into the receiver
`timescale 1ns/1ps
module dol_ser_model (
  // Serial link
  output logic link_clk,
  output logic link_data
);
  initial begin
    link_clk  = 1'b0;
    link_data = 1'b0;
  end
  // The clock stands still between calls, and the data line then shows the inverse
  // of its last bit, so a receiver that samples outside a frame cannot guess right
  task automatic bit_out(input logic b);
    link_data = b;
    #100 link_clk = 1'b1;
    #100 link_clk = 1'b0;
  endtask : bit_out
  // Each call starts half a receiver clock late so no pin moves on its edge
  task automatic train(input int n);
    #12.5;
    repeat (n) bit_out(~link_data);
    link_data = ~link_data;
  endtask : train
  // Nine bits, first bit is the MSB, even parity; bad flips the parity bit
  task automatic send_frame(input logic [7:0] w, input logic bad);
    #12.5;
    for (int i = 7; i >= 0; i--) bit_out(w[i]);
    bit_out(^w ^ bad);
    link_data = ~link_data;
  endtask : send_frame
endmodule : dol_ser_model

// ---- tb_deser_output_state_lock_ctrl.sv ----
// Self-checking bench for the output-state and lock control
`timescale 1ns/1ps
`include "dol_consts.svh"
module tb_deser_output_state_lock_ctrl;
  localparam logic [7:0] A_CTRL = 8'(4 * `DOL_IDX_CTRL);
  localparam logic [7:0] A_EQ   = 8'(4 * `DOL_IDX_EQ);
  localparam logic [7:0] A_STAT = 8'(4 * `DOL_IDX_STAT);
  localparam logic [7:0] A_IST  = 8'(4 * `DOL_IDX_IRQ_ST);
  localparam logic [7:0] A_ICLR = 8'(4 * `DOL_IDX_IRQ_CLR);
  localparam logic [7:0] A_IEN  = 8'(4 * `DOL_IDX_IRQ_EN);
  localparam logic [7:0] A_ECNT = 8'(4 * `DOL_IDX_ERRCNT);
  logic clk_sys = 1'b0, reset = 1'b1, pwr_on = 1'b0, drv_en = 1'b0, idle_sel = 1'b0;
  logic st_en = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, dat;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic        link_clk, link_data, lock_o, lock_oe, pass_o, pass_oe, dat_oe;
  logic        sclk, sclk_oe, mon_p, mon_n, irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [5:0]  tbl [4] = '{6'b101011, 6'b100000, 6'b101011, 6'b101111};
  int          error_cnt = 0, check_count = 0;
  wire  [5:0]  pins = {lock_oe, lock_o & lock_oe, pass_oe, pass_o & pass_oe, dat_oe, sclk_oe};

  always #12.5 clk_sys = ~clk_sys;

  dol_ser_model ser (.link_clk(link_clk), .link_data(link_data));
  dol_ctrl dut (
    .clk_sys(clk_sys), .reset(reset), .powerdown_bar(pwr_on), .output_drive_enable(drv_en),
    .idle_output_state_select(idle_sel), .self_test_enable(st_en), .link_clk(link_clk),
    .link_data(link_data), .lock_o(lock_o), .lock_oe(lock_oe), .pass_o(pass_o),
    .pass_oe(pass_oe), .audio_data(dat), .audio_data_oe(dat_oe), .sys_clk_out(sclk),
    .sys_clk_out_oe(sclk_oe), .equalizer_monitor_p(mon_p), .equalizer_monitor_n(mon_n),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================
  // Compare and bus tasks
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk_w
  task automatic chk_out(input logic [5:0] f, input logic [7:0] d);
    chk_w(32'({pins, dat & {8{dat_oe}}}), 32'({f, d}), "output state");
  endtask : chk_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk_w(32'(bresp), (n < 100) ? 32'(er) : 32'hffff, "write response");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    chk_w(32'(rresp), (n < 100) ? 32'(er) : 32'hffff, "read response");
  endtask : rd
  task automatic regs_zero();
    logic [7:0] al [3] = '{A_CTRL, A_EQ, A_IEN};
    logic [31:0] v;
    foreach (al[i]) begin
      rd(al[i], 2'b00, v);
      chk_w(v, 32'h0, "register default");
    end
  endtask : regs_zero
  task automatic pulse(input int e);
    int n, w;
    n = 0;
    w = 0;
    while (pass_o !== 1'b0 && n < 600) begin
      @(posedge clk_sys);
      n++;
    end
    while (pass_o === 1'b0 && w < 50) begin
      @(posedge clk_sys);
      w++;
    end
    chk_w(32'(w), 32'(e), "pass pulse width");
  endtask : pulse
  task automatic done_t(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : done_t
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // ==========================================================
  // Watchdog, far beyond the roughly 17 us the tests need
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end

  // ==========================================================
  // Tests
  initial begin
    int n;
    logic prev;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    regs_zero();
    rd(8'h00, 2'b10, rd_v);
    chk_w(rd_v, 32'h0, "unmapped read data");
    wr(8'h3c, 32'h1, 2'b10);
    wr(8'h09, 32'h1, 2'b10);
    done_t("registers");
    chk_w(32'({pins, mon_p, mon_n}), 32'h0, "powered down");
    pwr_on <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      drv_en <= i[1];
      idle_sel <= i[0];
      repeat (8) @(posedge clk_sys);
      chk_out(tbl[i], 8'h00);
      chk_w(32'(sclk & sclk_oe), 32'h0, "idle system clock");
    end
    chk_w(32'(mon_n), 32'(!mon_p), "monitor pair");
    idle_sel <= 1'b0;
    wr(A_CTRL, 32'h20, 2'b00);
    n = 0;
    prev = sclk;
    repeat (40) begin
      @(posedge clk_sys);
      if (sclk !== prev) n++;
      prev = sclk;
    end
    chk_w(32'(n >= 9 && n <= 11), 32'h1, "oscillator toggles");
    wr(A_EQ, 32'h13, 2'b00);
    rd(A_STAT, 2'b00, rd_v);
    chk_w(rd_v & 32'hf0, 32'h90, "manual eq level");
    wr(A_IEN, 32'h7, 2'b00);
    pwr_on <= 1'b0;
    repeat (6) @(posedge clk_sys);
    pwr_on <= 1'b1;
    repeat (6) @(posedge clk_sys);
    regs_zero();
    done_t("output table");
    wr(A_IEN, 32'h7, 2'b00);
    wr(A_ICLR, 32'h7, 2'b00);
    idle_sel <= 1'b1;
    ser.train(16);
    repeat (3) @(posedge clk_sys);
    chk_w(32'(lock_o), 32'h1, "lock after training");
    ser.send_frame(8'ha5, 1'b0);
    repeat (16) @(posedge clk_sys);
    chk_out(6'b111111, 8'ha5);
    chk_w(32'(irq), 32'h1, "lock interrupt");
    idle_sel <= 1'b0;
    ser.send_frame(8'hff, 1'b0);
    repeat (16) @(posedge clk_sys);
    chk_out(6'b111011, 8'h00);
    idle_sel <= 1'b1;
    st_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    repeat (2) begin
      fork
        ser.send_frame(8'h5a, 1'b1);
        pulse(4);
      join
    end
    rd(A_ECNT, 2'b00, rd_v);
    chk_w(rd_v, 32'h2, "errored frame count");
    rd(A_IST, 2'b00, rd_v);
    chk_w(rd_v, 32'h5, "event status");
    done_t("lock and self-test");
    wr(A_IEN, 32'h0, 2'b00);
    repeat (60) @(posedge clk_sys);
    chk_w(32'({lock_o, irq}), 32'h0, "lock lost, masked");
    rd(A_IST, 2'b00, rd_v);
    chk_w(rd_v, 32'h7, "lock lost status");
    wr(A_IEN, 32'h2, 2'b00);
    repeat (3) @(posedge clk_sys);
    chk_w(32'(irq), 32'h1, "unmasked interrupt");
    wr(A_ICLR, 32'h7, 2'b00);
    repeat (3) @(posedge clk_sys);
    chk_w(32'(irq), 32'h0, "cleared interrupt");
    rd(A_IST, 2'b00, rd_v);
    chk_w(rd_v, 32'h0, "cleared status");
    done_t("interrupts");
    conclude();
  end
endmodule : tb_deser_output_state_lock_ctrl
